// File: trig_store_consts.vh
// Constants for the trigger, update-busy and store control block.
// Assumes a 200 MHz system clock; included by bare name.
`ifndef TRIG_STORE_CONSTS_VH
`define TRIG_STORE_CONSTS_VH

// Register offsets
`define OFS_STATUS       8'hd0
`define OFS_CODE         8'h21
`define OFS_MHI          8'h25
`define OFS_MLO          8'h26
`define OFS_SETUP        8'hd1
`define OFS_INSET        8'hd2
`define OFS_ACTION       8'hd3

// action_control fields
`define ACT_RESTART      3:0
`define ACT_PROG         4
`define ACT_RELOAD       5
`define ACT_SW_MHI       6
`define ACT_SW_MLO       7
`define ACT_SW_WAVE      8
`define ACT_TRIG_EN      10
`define RESTART_CODE     4'ha

// status fields
`define ST_UPD_BUSY      0
`define ST_STORE_BUSY    1
`define ST_USER_ALARM    2
`define ST_FACT_ALARM    3

// Other fields
`define INSET_FUNC       13:11
`define SETUP_PD         4:3
`define CODE_FIELD       11:2
`define PD_ON            2'h0
`define PD_10K           2'h1
`define PD_HIZ           2'h3

// Trigger function selects
`define FN_PWR_HIZ       3'h0
`define FN_PWR_10K       3'h1
`define FN_MARGIN        3'h2
`define FN_WAVE          3'h3
`define FN_ALARM_HI      3'h4
`define FN_ALARM_MID     3'h5
`define FN_ALARM_LO      3'h6
`define FN_ADDR          3'h7

// Factory defaults and the bits held in the store
`define DEF_SETUP        16'h01f8
`define DEF_ZERO         16'h0000
`define MASK_SETUP       16'h2fff
`define MASK_INSET       16'hf83f
`define MASK_ACTION      16'h0400
`define MASK_CODE        16'h0ffc
`define MASK_MARGIN      16'h0ff0

// Store geometry and timing
`define CRC_POLY         10'h233
`define CRC_ZERO         10'h000
`define STORE_WORDS      6
`define STORE_LAST       3'h5
`define STORE_STEP_NS    1000
`define CLK_NS           5
`define STORE_STEP_CYC   ((`STORE_STEP_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// File: trig_store_ctrl.v
// Trigger pin decoding, update-busy tracking and configuration store control.
// Assumes a register port driven by an I2C target engine on sys_clk, an
// asynchronous trigger pin, and a slew engine that reports done.
`timescale 1ns/100ps
`include "trig_store_consts.vh"

module trig_store_ctrl #(
  parameter [15:0] FACTORY_WORD = 16'h5a3c  // Factory region content, arbitrary value
) (
  input  wire        sys_clk,            // System clock, 200 MHz
  input  wire        rst,                // Power-on reset, synchronous, active high
  input  wire        reg_wr,             // Register write strobe
  input  wire        reg_rd,             // Register read strobe
  input  wire [7:0]  reg_addr,           // Register offset
  input  wire [15:0] reg_wdata,          // Register write data
  input  wire        frame_end,          // Write frame ended, one-cycle pulse
  input  wire        op_done,            // Margin transition finished, pulse
  input  wire        trigger_input_pin,  // Trigger pin, asynchronous
  output reg  [15:0] reg_rdata,          // Register read data
  output reg  [9:0]  output_code,        // Code applied to the output
  output reg  [1:0]  output_pd,          // Power-down state of the output
  output reg         margin_go,          // Start margin transition, pulse
  output reg         margin_to_high,     // Margin target is the upper code
  output reg         wave_run,           // Waveform generation running
  output reg  [2:0]  alarm_run,          // High, mid, low alarm patterns running
  output reg         addr_update_en,     // Target address update allowed
  output reg         update_busy,        // Converter update in progress
  output reg         store_busy,         // Store program or reload running
  output reg         user_alarm,         // User region CRC failed
  output reg         factory_alarm       // Factory region CRC failed
);

  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_LOAD = 2'h1;
  localparam [1:0] S_PROG = 2'h2;
  localparam [1:0] S_BOOT = 2'h3;
  localparam integer STEP_CYC = `STORE_STEP_CYC;

  function [9:0] crc10;
    input [9:0]  c_in;
    input [15:0] d;
    integer      i;
    reg   [9:0]  c;
    begin
      c = c_in;
      for (i = 15; i >= 0; i = i - 1) begin
        if (c[9] ^ d[i])
          c = {c[8:0], 1'b0} ^ `CRC_POLY;
        else
          c = {c[8:0], 1'b0};
      end
      crc10 = c;
    end
  endfunction

  localparam [9:0] FACTORY_CRC = crc10(`CRC_ZERO, FACTORY_WORD);

  reg [15:0] setup;
  reg [15:0] inset;
  reg        trig_en;
  reg        reload_flag;
  reg [15:0] code;
  reg [15:0] mhi;
  reg [15:0] mlo;
  reg        code_pending;
  reg        margin_active;
  reg        margin_pend;
  reg        pend_high;
  reg        booting;
  reg        restart;
  reg [1:0]  state;
  reg [2:0]  idx;
  reg [7:0]  cnt;
  reg [9:0]  crc;
  reg [15:0] store_mem [0:`STORE_WORDS-1];
  reg [9:0]  store_crc;
  reg        pin_s1;
  reg        pin_s2;
  reg        pin_s3;
  integer    k;

  // Blank store holds factory defaults with a matching CRC
  initial begin
    for (k = 0; k < `STORE_WORDS; k = k + 1)
      store_mem[k] = (k == 0) ? (`DEF_SETUP & `MASK_SETUP) : `DEF_ZERO;
    store_crc = crc10(crc10(crc10(crc10(crc10(crc10(`CRC_ZERO, store_mem[0]),
                store_mem[1]), store_mem[2]), store_mem[3]), store_mem[4]), store_mem[5]);
  end

  // Trigger pin synchroniser; only pin_s2 and later are examined
  always @(posedge sys_clk) begin
    if (rst) begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      pin_s3 <= 1'b0;
    end else begin
      pin_s1 <= trigger_input_pin;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  wire       pin_rise  = pin_s2 & ~pin_s3;
  wire       pin_fall  = ~pin_s2 & pin_s3;
  wire [2:0] func      = inset[`INSET_FUNC];
  wire       boot_cmd  = (state == S_BOOT) & trig_en;
  wire       edge_cmd  = (state != S_BOOT) & ~booting & trig_en & (pin_rise | pin_fall);
  wire       cmd_fire  = boot_cmd | edge_cmd;
  wire       cmd_up    = (state == S_BOOT) ? pin_s2 : pin_rise;
  wire       step_end  = (cnt == STEP_CYC[7:0] - 8'h01);
  wire       last_word = (idx == `STORE_LAST);
  wire       map_pwr   = trig_en & ((func == `FN_PWR_HIZ) | (func == `FN_PWR_10K));
  wire       map_mrg   = trig_en & (func == `FN_MARGIN);
  wire       map_wave  = trig_en & (func == `FN_WAVE);

  reg [15:0] prog_word;
  reg [15:0] load_mask;
  always @* begin
    case (idx)
      3'h0: begin prog_word = setup; load_mask = `MASK_SETUP; end
      3'h1: begin prog_word = inset; load_mask = `MASK_INSET; end
      3'h2: begin prog_word = {5'h00, trig_en, 10'h000}; load_mask = `MASK_ACTION; end
      3'h3: begin prog_word = code; load_mask = `MASK_CODE; end
      3'h4: begin prog_word = mhi; load_mask = `MASK_MARGIN; end
      default: begin prog_word = mlo; load_mask = `MASK_MARGIN; end
    endcase
  end

  wire [15:0] load_word = store_mem[idx] & load_mask;
  wire [9:0]  next_crc  = crc10(crc, (state == S_PROG) ? (prog_word & load_mask) : load_word);

  always @(posedge sys_clk) begin
    if (rst || restart) begin
      setup          <= `DEF_SETUP;
      inset          <= `DEF_ZERO;
      trig_en        <= 1'b0;
      reload_flag    <= 1'b0;
      code           <= `DEF_ZERO;
      mhi            <= `DEF_ZERO;
      mlo            <= `DEF_ZERO;
      code_pending   <= 1'b0;
      margin_active  <= 1'b0;
      margin_pend    <= 1'b0;
      pend_high      <= 1'b0;
      booting        <= 1'b1;
      restart        <= 1'b0;
      state          <= S_LOAD;
      store_busy     <= 1'b1;
      idx            <= 3'h0;
      cnt            <= 8'h00;
      crc            <= `CRC_ZERO;
      reg_rdata      <= 16'h0000;
      output_code    <= 10'h000;
      output_pd      <= `PD_HIZ;
      margin_go      <= 1'b0;
      margin_to_high <= 1'b0;
      wave_run       <= 1'b0;
      alarm_run      <= 3'h0;
      addr_update_en <= 1'b0;
      update_busy    <= 1'b0;
      user_alarm     <= 1'b0;
      factory_alarm  <= 1'b0;
    end else begin
      margin_go <= 1'b0;

      // Store sequencer: one word per step, CRC folded as words pass
      if (state == S_LOAD || state == S_PROG) begin
        cnt <= step_end ? 8'h00 : cnt + 8'h01;
        if (step_end) begin
          crc <= next_crc;
          idx <= idx + 3'h1;
          if (state == S_PROG) begin
            store_mem[idx] <= prog_word & load_mask;
          end else begin
            case (idx)
              3'h0: setup <= load_word | (`DEF_SETUP & ~`MASK_SETUP);
              3'h1: inset <= load_word;
              3'h2: trig_en <= load_word[`ACT_TRIG_EN];
              3'h3: code <= load_word;
              3'h4: mhi <= load_word;
              default: mlo <= load_word;
            endcase
          end
          if (last_word) begin
            idx        <= 3'h0;
            crc        <= `CRC_ZERO;
            if (state == S_PROG) begin
              store_crc  <= next_crc;
              state      <= S_IDLE;
              store_busy <= 1'b0;
            end else begin
              reload_flag <= 1'b0;
              output_code <= load_word[`CODE_FIELD];
              if (idx == 3'h3)
                output_code <= load_word[`CODE_FIELD];
              else
                output_code <= code[`CODE_FIELD];
              if (next_crc != store_crc)
                user_alarm <= 1'b1;
              if (crc10(`CRC_ZERO, FACTORY_WORD) != FACTORY_CRC)
                factory_alarm <= 1'b1;
              if (next_crc != store_crc || crc10(`CRC_ZERO, FACTORY_WORD) != FACTORY_CRC) begin
                setup       <= `DEF_SETUP;
                inset       <= `DEF_ZERO;
                trig_en     <= 1'b0;
                code        <= `DEF_ZERO;
                mhi         <= `DEF_ZERO;
                mlo         <= `DEF_ZERO;
                output_code <= 10'h000;
              end
              state      <= booting ? S_BOOT : S_IDLE;
              store_busy <= booting;
            end
          end
        end
      end else if (state == S_BOOT) begin
        state      <= S_IDLE;
        booting    <= 1'b0;
        store_busy <= 1'b0;
      end

      // Trigger pin commands
      if (cmd_fire) begin
        case (func)
          `FN_PWR_HIZ: setup[`SETUP_PD] <= cmd_up ? `PD_ON : `PD_HIZ;
          `FN_PWR_10K: setup[`SETUP_PD] <= cmd_up ? `PD_ON : `PD_10K;
          `FN_MARGIN: begin
            if (margin_active && !op_done) begin
              margin_pend <= 1'b1;
              pend_high   <= cmd_up;
            end else begin
              margin_go      <= 1'b1;
              margin_to_high <= cmd_up;
              margin_active  <= 1'b1;
              margin_pend    <= 1'b0;
            end
          end
          `FN_WAVE:      wave_run <= cmd_up;
          `FN_ALARM_HI:  alarm_run[2] <= cmd_up;
          `FN_ALARM_MID: alarm_run[1] <= cmd_up;
          `FN_ALARM_LO:  alarm_run[0] <= cmd_up;
          default:       addr_update_en <= cmd_up;
        endcase
      end else if (op_done && margin_active) begin
        margin_pend <= 1'b0;
        if (margin_pend) begin
          margin_go      <= 1'b1;
          margin_to_high <= pend_high;
        end else begin
          margin_active <= 1'b0;
        end
      end

      // Code reaches the output only when its write frame closes
      if (frame_end && code_pending && state == S_IDLE) begin
        output_code  <= code[`CODE_FIELD];
        code_pending <= 1'b0;
      end

      // Host writes; all refused while the store is busy
      if (reg_wr && state == S_IDLE) begin
        case (reg_addr)
          `OFS_CODE: begin
            code         <= reg_wdata;
            code_pending <= 1'b1;
          end
          `OFS_MHI:   mhi <= reg_wdata;
          `OFS_MLO:   mlo <= reg_wdata;
          `OFS_INSET: inset <= reg_wdata;
          `OFS_SETUP: begin
            setup <= reg_wdata;
            if (map_pwr)
              setup[`SETUP_PD] <= setup[`SETUP_PD];
          end
          `OFS_ACTION: begin
            trig_en <= reg_wdata[`ACT_TRIG_EN];
            if (!map_wave)
              wave_run <= reg_wdata[`ACT_SW_WAVE];
            if (!map_mrg && !margin_active &&
                (reg_wdata[`ACT_SW_MHI] ^ reg_wdata[`ACT_SW_MLO])) begin
              margin_go      <= 1'b1;
              margin_to_high <= reg_wdata[`ACT_SW_MHI];
              margin_active  <= 1'b1;
            end
            if (reg_wdata[`ACT_RESTART] == `RESTART_CODE) begin
              restart <= 1'b1;
            end else if (reg_wdata[`ACT_PROG]) begin
              state      <= S_PROG;
              store_busy <= 1'b1;
            end else if (reg_wdata[`ACT_RELOAD]) begin
              reload_flag <= 1'b1;
              state       <= S_LOAD;
              store_busy  <= 1'b1;
            end
          end
          default: ;
        endcase
      end

      // Register reads; the host keeps off the code and margin registers while store_busy is high
      if (reg_rd) begin
        case (reg_addr)
          `OFS_CODE:   reg_rdata <= code;
          `OFS_MHI:    reg_rdata <= mhi;
          `OFS_MLO:    reg_rdata <= mlo;
          `OFS_SETUP:  reg_rdata <= setup;
          `OFS_INSET:  reg_rdata <= inset;
          `OFS_ACTION: reg_rdata <= {5'h00, trig_en, 1'b0, wave_run, 2'h0, reload_flag, 5'h00};
          `OFS_STATUS: reg_rdata <= {12'h000, factory_alarm, user_alarm, store_busy, update_busy};
          default:     reg_rdata <= 16'h0000;
        endcase
      end

      output_pd   <= setup[`SETUP_PD];
      // Lags its causes by one cycle so the output stays a plain flop
      update_busy <= margin_active | wave_run | (|alarm_run);
    end
  end

endmodule

// File: trig_store_ctrl_sva.sv
// Port-level assertions for the trigger, update-busy and store control block.
// Assumes trig_store_ctrl on one clock, sys_clk, with synchronous active-high rst.
`timescale 1ns/100ps
module trig_store_chk (
  input logic       sys_clk,        // System clock
  input logic       rst,            // Synchronous reset
  input logic       reg_wr,         // Register write strobe
  input logic       frame_end,      // Write frame ended
  input logic       margin_go,      // Margin start pulse
  input logic       wave_run,       // Waveform running
  input logic       update_busy,    // Converter update in progress
  input logic       store_busy,     // Store operation running
  input logic       user_alarm,     // User region alarm
  input logic       factory_alarm,  // Factory region alarm
  input logic [9:0] output_code,    // Applied code
  input logic [1:0] output_pd       // Output power state
);
  logic [11:0] busy_cnt;

  // Counts busy cycles so a stuck store shows up well before the watchdog
  always @(posedge sys_clk) begin
    if (rst || !store_busy) busy_cnt <= 12'h000;
    else busy_cnt <= busy_cnt + 12'h001;
  end

  // No disable here: the antecedent is the reset itself
  a_reset_state: assert property (@(posedge sys_clk) rst |=>
    store_busy && output_pd == 2'h3) else $error("reset state wrong");
  a_store_bounded: assert property (@(posedge sys_clk) disable iff (rst)
    busy_cnt < 12'h4ba) else $error("store busy too long");
  a_margin_pulse: assert property (@(posedge sys_clk) disable iff (rst)
    margin_go |=> !margin_go) else $error("margin start longer than one cycle");
  a_margin_busy: assert property (@(posedge sys_clk) disable iff (rst)
    margin_go |-> ##[1:2] update_busy) else $error("no update busy on margin");
  a_wave_busy: assert property (@(posedge sys_clk) disable iff (rst)
    wave_run && !reg_wr && !$past(reg_wr) |=> update_busy)
    else $error("no update busy while waveform runs");
  a_code_frame: assert property (@(posedge sys_clk) disable iff (rst)
    $changed(output_code) |-> $past(frame_end) || $past(store_busy) || $past(reg_wr)
    || $past(reg_wr, 2)) else $error("code applied outside frame end");
  a_user_sticky: assert property (@(posedge sys_clk) disable iff (rst)
    user_alarm && !reg_wr && !$past(reg_wr) |=> user_alarm) else $error("user alarm lost");
  a_fact_sticky: assert property (@(posedge sys_clk) disable iff (rst)
    factory_alarm && !reg_wr && !$past(reg_wr) |=> factory_alarm)
    else $error("factory alarm lost");
endmodule

bind trig_store_ctrl trig_store_chk i_chk (.sys_clk(sys_clk), .rst(rst), .reg_wr(reg_wr),
  .frame_end(frame_end), .margin_go(margin_go), .wave_run(wave_run),
  .update_busy(update_busy), .store_busy(store_busy), .user_alarm(user_alarm),
  .factory_alarm(factory_alarm), .output_code(output_code), .output_pd(output_pd));

// File: trig_host_model.sv
// Far-side model: register master in place of the I2C target engine, slew
// engine done pulses and the logic driving the trigger pin.
// Assumes the block samples on the rising edge; this drives all but the trigger pin on the falling one.
`timescale 1ns/100ps
`include "trig_store_consts.vh"
module trig_host_model (
  input  logic        sys_clk,           // System clock
  input  logic [15:0] reg_rdata,         // Read data
  input  logic        update_busy,       // Converter update in progress
  input  logic        store_busy,        // Store operation running
  output logic        reg_wr,            // Write strobe
  output logic        reg_rd,            // Read strobe
  output logic [7:0]  reg_addr,          // Register offset
  output logic [15:0] reg_wdata,         // Write data
  output logic        frame_end,         // Write frame ended
  output logic        op_done,           // Margin transition finished
  output logic        trigger_input_pin  // Trigger pin
);
  initial begin
    {reg_wr, reg_rd, frame_end, op_done, trigger_input_pin} = 5'h00;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
  end

  function automatic logic conv(input logic [7:0] a);
    conv = (a == `OFS_CODE) || (a == `OFS_MHI) || (a == `OFS_MLO);
  endfunction

  // Released address and data are inverted so stale values cannot pass
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    wait (!(conv(a) && update_busy));
    @(negedge sys_clk);
    {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
    @(negedge sys_clk);
    {reg_addr, reg_wdata, reg_wr} = {~a, ~d, 1'b0};
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    wait (!(conv(a) && store_busy));
    @(negedge sys_clk);
    {reg_addr, reg_rd} = {a, 1'b1};
    @(negedge sys_clk);
    {reg_addr, reg_rd} = {~a, 1'b0};
    d = reg_rdata;
  endtask

  task automatic pulse(input logic done);
    @(negedge sys_clk);
    {op_done, frame_end} = {done, !done};
    @(negedge sys_clk);
    {op_done, frame_end} = 2'h0;
  endtask

  // Pin moves off the clock grid, then holds for one 80 ns link period
  task automatic pin(input logic v);
    #41.3 trigger_input_pin = v;
    #80;
  endtask
endmodule

// File: trig_store_ctrl_bench.sv
// Self-checking bench for trig_store_ctrl with the host model on its far side.
// Assumes a store that boots with defaults and valid check values.
`timescale 1ns/100ps
`include "trig_store_consts.vh"
module trig_store_ctrl_bench;
  logic        sys_clk, rst, reg_wr, reg_rd, frame_end, op_done, trigger_input_pin;
  logic        margin_go, margin_to_high, wave_run, addr_update_en, update_busy;
  logic        store_busy, user_alarm, factory_alarm;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rv;
  logic [9:0]  output_code;
  logic [1:0]  output_pd;
  logic [2:0]  alarm_run;
  int          error_cnt, compares;
  // Rows: function select, pin level, expected observed output
  logic [6:0]  rows [16] = '{7'h08, 7'h03, 7'h18, 7'h11, 7'h29, 7'h20, 7'h39, 7'h30,
                             7'h4c, 7'h40, 7'h5a, 7'h50, 7'h69, 7'h60, 7'h79, 7'h70};

  trig_store_ctrl i_dut (.sys_clk(sys_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .frame_end(frame_end), .op_done(op_done),
    .trigger_input_pin(trigger_input_pin), .reg_rdata(reg_rdata), .output_code(output_code),
    .output_pd(output_pd), .margin_go(margin_go), .margin_to_high(margin_to_high),
    .wave_run(wave_run), .alarm_run(alarm_run), .addr_update_en(addr_update_en),
    .update_busy(update_busy), .store_busy(store_busy), .user_alarm(user_alarm),
    .factory_alarm(factory_alarm));

  trig_host_model i_host (.sys_clk(sys_clk), .reg_rdata(reg_rdata),
    .update_busy(update_busy), .store_busy(store_busy), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .frame_end(frame_end), .op_done(op_done),
    .trigger_input_pin(trigger_input_pin));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic summarize;
    if (error_cnt == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic wait_store;
    int n;
    n = 0;
    repeat (3) @(negedge sys_clk);
    while (store_busy !== 1'b0 && n < 1400) begin
      @(negedge sys_clk);
      n++;
    end
    chk(16'(store_busy), 16'h0, "store busy stuck");
  endtask

  function automatic logic [2:0] obs(input logic [2:0] fn);
    case (fn)
      `FN_PWR_HIZ, `FN_PWR_10K: obs = {1'b0, output_pd};
      `FN_MARGIN: obs = {2'h0, margin_to_high};
      `FN_WAVE: obs = {2'h0, wave_run};
      `FN_ADDR: obs = {2'h0, addr_update_en};
      default: obs = alarm_run;
    endcase
  endfunction

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Whole run is near 7800 cycles; this leaves ample margin
  initial begin
    #300000;
    error_cnt++;
    $display("[FAIL] %0t watchdog expired", $time);
    summarize;
  end

  initial begin
    rst = 1'b1;
    repeat (16) @(negedge sys_clk);
    rst = 1'b0;
    chk(16'(output_pd), 16'h3, "output not Hi-Z during load");
    wait_store;
    i_host.rd(`OFS_STATUS, rv);
    chk(rv & 16'h000e, 16'h0, "status after boot");
    i_host.rd(`OFS_ACTION, rv);
    chk(rv & 16'h0400, 16'h0, "pin enabled by default");
    i_host.wr(`OFS_CODE, 16'h0abc);
    chk(16'(output_code), 16'h0, "code applied before frame end");
    i_host.pulse(1'b0);
    repeat (2) @(negedge sys_clk);
    chk(16'(output_code), 16'h02af, "code after frame end");
    i_host.wr(`OFS_ACTION, 16'h0400);
    foreach (rows[i]) begin
      i_host.wr(`OFS_INSET, {2'h0, rows[i][6:4], 11'h000});
      i_host.pin(rows[i][3]);
      chk(16'(obs(rows[i][6:4])), 16'(rows[i][2:0]), "pin command");
      if (rows[i][6:4] == `FN_MARGIN) begin
        chk(16'(update_busy), 16'h1, "no busy during margin");
        i_host.pulse(1'b1);
        repeat (3) @(negedge sys_clk);
        chk(16'(update_busy), 16'h0, "busy after margin done");
      end
    end
    i_host.wr(`OFS_INSET, {2'h0, `FN_MARGIN, 11'h000});
    i_host.pin(1'b1);
    i_host.pin(1'b0);
    chk(16'(margin_to_high), 16'h1, "held margin edge acted early");
    i_host.pulse(1'b1);
    chk(16'(margin_to_high), 16'h0, "held margin edge lost");
    chk(16'(update_busy), 16'h1, "busy dropped between margin steps");
    i_host.pulse(1'b1);
    i_host.wr(`OFS_INSET, {2'h0, `FN_WAVE, 11'h000});
    i_host.wr(`OFS_ACTION, 16'h0500);
    repeat (3) @(negedge sys_clk);
    chk(16'(wave_run), 16'h0, "software wave ran while mapped");
    i_host.wr(`OFS_ACTION, 16'h0000);
    i_host.pin(1'b1);
    chk(16'(wave_run), 16'h0, "pin acted while disabled");
    i_host.wr(`OFS_ACTION, 16'h0400);
    repeat (8) @(negedge sys_clk);
    chk(16'(wave_run), 16'h0, "static level acted");
    i_host.pin(1'b0);
    i_host.wr(`OFS_MHI, 16'h0ff7);
    i_host.wr(`OFS_ACTION, 16'h0410);
    @(negedge sys_clk);
    chk(16'(store_busy), 16'h1, "program not busy");
    i_host.wr(`OFS_CODE, 16'h0000);
    wait_store;
    i_host.rd(`OFS_CODE, rv);
    chk(rv, 16'h0abc, "write taken while store busy");
    i_host.wr(`OFS_CODE, 16'h0123);
    i_host.wr(`OFS_MHI, 16'h0001);
    i_host.wr(`OFS_ACTION, 16'h0420);
    @(negedge sys_clk);
    i_host.rd(`OFS_ACTION, rv);
    chk(rv & 16'h0020, 16'h0020, "reload bit low while running");
    wait_store;
    i_host.rd(`OFS_ACTION, rv);
    chk(rv & 16'h0020, 16'h0, "reload bit not cleared");
    i_host.rd(`OFS_CODE, rv);
    chk(rv, 16'h0abc, "reloaded code");
    i_host.rd(`OFS_MHI, rv);
    chk(rv, 16'h0ff0, "reloaded upper margin");
    i_host.pin(1'b1);
    i_host.wr(`OFS_ACTION, 16'h000a);
    repeat (2) @(negedge sys_clk);
    chk(16'(store_busy), 16'h1, "restart did not reload");
    wait_store;
    repeat (4) @(negedge sys_clk);
    chk(16'(wave_run), 16'h1, "boot level not executed");
    chk(16'(output_code), 16'h02af, "code after restart");
    i_host.rd(`OFS_STATUS, rv);
    chk(rv & 16'h000f, 16'h0001, "status after restart");
    i_host.pin(1'b0);
    i_host.wr(`OFS_MHI, 16'h0550);
    i_host.wr(`OFS_ACTION, 16'h0410);
    // Power lost after the upper margin word lands but before the check value
    repeat (1100) @(negedge sys_clk);
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    chk(16'(output_pd), 16'h3, "output not Hi-Z after second reset");
    wait_store;
    chk(16'(user_alarm), 16'h1, "torn store not flagged");
    i_host.rd(`OFS_STATUS, rv);
    chk(rv & 16'h000f, 16'h0004, "user alarm not reported alone");
    i_host.rd(`OFS_MHI, rv);
    chk(rv, 16'h0000, "defaults not forced on bad store");
    i_host.wr(`OFS_MHI, 16'h0123);
    i_host.rd(`OFS_MHI, rv);
    chk(rv, 16'h0123, "register not writable under alarm");
    summarize;
  end
endmodule
